// [src/ptrd_top.sv]
// transmit electrical idle and far-end receiver detect control
`timescale 1ns/1ps
// What this block does
// - detection runs only in the p1 power state; other states ignore requests
// - detect request steps transmitter common mode and senses the output response
// - receiver found gives one-cycle done pulse with status code 3'b011
// - result comes after nonzero latency; mac waits for done pulse
// - while force-idle is high the transmitter driver stays tri-stated
// - in p1 the transmitter output stays tri-stated
// - slow common-mode response means receiver present, fast means absent
module ptrd_top
  import ptrd_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // requests from the mac
  input wire logic force_idle_i,
  input wire logic detect_rx_i,
  input wire logic [1:0] power_state_i,
  // analog sense: high once the stepped output has crossed the threshold
  input wire logic cm_cross_i,
  // transmitter control
  output logic tx_drive_en_o,
  output logic cm_step_o,
  // answers to the mac
  output logic done_o,
  output logic [2:0] status_o
);
  ptrd_state_type state;
  ptrd_state_type next_state;
  logic [PTRD_CNT_W-1:0] lead_cnt;
  logic next_done;
  logic [2:0] next_status;
  logic timer_load;
  logic [PTRD_CNT_W-1:0] timer_count;
  logic timer_expired;

  localparam logic [PTRD_CNT_W-1:0] LEAD_NEED = PTRD_CNT_W'(PTRD_IDLE_LEAD_CYC);
  localparam logic [PTRD_CNT_W-1:0] SETTLE_LEN = PTRD_CNT_W'(PTRD_SETTLE_CYC);
  localparam logic [PTRD_CNT_W-1:0] SENSE_LEN = PTRD_CNT_W'(PTRD_SENSE_CYC);

  wire logic in_p1 = (power_state_i == PTRD_PWR_P1);
  // idle lead counted so a request arriving early waits until the driver is off
  wire logic lead_met = (lead_cnt >= LEAD_NEED);
  // any gap in the idle request restarts the lead count
  wire logic lead_clear = !force_idle_i;
  // both requests and p1 needed; anything else is not acted on
  wire logic start_req = force_idle_i && detect_rx_i && in_p1 && lead_met;
  wire logic left_p1 = !in_p1;
  wire logic idle_dropped = !force_idle_i;
  // an abort gives no result; the mac sees a request that was never answered
  wire logic abort = left_p1 || idle_dropped;
  wire logic busy = (state != PTRD_IDLE);
  wire logic idle_forced = force_idle_i || in_p1;
  // tri-state whenever forced idle, in p1, or detecting
  wire logic next_drive_en = !(idle_forced || busy);

  // result decode; a crossing inside the window wins over the window running out
  wire logic step_over = timer_expired;
  wire logic fast_seen = cm_cross_i;
  wire logic slow_seen = !cm_cross_i && timer_expired;
  wire logic result_ready = fast_seen || slow_seen;
  wire logic [2:0] result_code = fast_seen ? PTRD_STAT_NONE : PTRD_STAT_FOUND;
  // one result per request: the request must drop before the next one
  wire logic request_gone = !detect_rx_i;
  wire logic next_cm_step = (next_state == PTRD_STEP) || (next_state == PTRD_SENSE);

  always_comb
  begin
    next_state = state;
    next_done = 1'b0;
    next_status = status_o;
    timer_load = 1'b0;
    timer_count = SETTLE_LEN;
    case (state)
      PTRD_IDLE:
      begin
        // take: the settle time loads first
        if (start_req)
        begin
          next_state = PTRD_STEP;
          timer_load = 1'b1;
        end
      end
      PTRD_STEP:
      begin
        if (abort)
        begin
          next_state = PTRD_IDLE;
        end
        else if (step_over)
        begin
          // settled: open the sense window
          next_state = PTRD_SENSE;
          timer_load = 1'b1;
          timer_count = SENSE_LEN;
        end
      end
      PTRD_SENSE:
      begin
        if (abort)
        begin
          next_state = PTRD_IDLE;
        end
        else if (result_ready)
        begin
          // fast crossing: nobody loads the line; still slow at the end: a receiver is there
          next_state = PTRD_DONE;
          next_done = 1'b1;
          next_status = result_code;
        end
      end
      PTRD_DONE:
      begin
        next_state = PTRD_WAIT_LOW;
      end
      PTRD_WAIT_LOW:
      begin
        // wait for the detect request to drop
        if (request_gone)
        begin
          next_state = PTRD_IDLE;
        end
      end
      default:
      begin
        next_state = PTRD_IDLE;
      end
    endcase
  end

  ptrd_cycle_timer u_timer (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .load_i(timer_load),
    .count_i(timer_count),
    .expired_o(timer_expired)
  );

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      lead_cnt <= '0;
    end
    else if (lead_clear)
    begin
      lead_cnt <= '0;
    end
    else if (!lead_met)
    begin
      lead_cnt <= lead_cnt + 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state <= PTRD_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // next_done is high in one state only, so the pulse never stretches
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= next_done;
    end
  end

  // status holds until the next result
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      status_o <= PTRD_STAT_NONE;
    end
    else
    begin
      status_o <= next_status;
    end
  end

  // registered enable: lags the idle request by one cycle
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tx_drive_en_o <= 1'b0;
    end
    else
    begin
      tx_drive_en_o <= next_drive_en;
    end
  end

  // step stays applied through settle and sense
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cm_step_o <= 1'b0;
    end
    else
    begin
      cm_step_o <= next_cm_step;
    end
  end
endmodule : ptrd_top

// [src/ptrd_pkg.sv]
// constants for the transmit idle and far-end receiver detect block
package ptrd_pkg;
  // power state encoding, two bits as in the pipe interface
  localparam logic [1:0] PTRD_PWR_P0 = 2'h0;
  localparam logic [1:0] PTRD_PWR_P0S = 2'h1;
  localparam logic [1:0] PTRD_PWR_P1 = 2'h2;
  localparam logic [1:0] PTRD_PWR_P2 = 2'h3;
  // status codes
  localparam logic [2:0] PTRD_STAT_FOUND = 3'h3;
  localparam logic [2:0] PTRD_STAT_NONE = 3'h0;
  // clock rate and timing
  localparam int PTRD_CLK_MHZ = 25;
  localparam int PTRD_IDLE_LEAD_CYC = 10;
  // common-mode step settle time in ns before sensing starts
  localparam int PTRD_SETTLE_NS = 200;
  localparam int PTRD_SETTLE_CYC_RAW = (PTRD_SETTLE_NS * PTRD_CLK_MHZ) / 1000;
  localparam int PTRD_SETTLE_CYC = (PTRD_SETTLE_CYC_RAW < 1) ? 1 : PTRD_SETTLE_CYC_RAW;
  // sense window; a slow response still low at its end means receiver present
  localparam int PTRD_SENSE_NS = 400;
  localparam int PTRD_SENSE_CYC_RAW = (PTRD_SENSE_NS * PTRD_CLK_MHZ) / 1000;
  localparam int PTRD_SENSE_CYC = (PTRD_SENSE_CYC_RAW < 1) ? 1 : PTRD_SENSE_CYC_RAW;
  localparam int PTRD_CNT_W = 8;
  typedef enum logic [2:0] {
    PTRD_IDLE,
    PTRD_STEP,
    PTRD_SENSE,
    PTRD_DONE,
    PTRD_WAIT_LOW
  } ptrd_state_type;
endpackage : ptrd_pkg

// [src/ptrd_cycle_timer.sv]
// loadable down-counter with terminal pulse
`timescale 1ns/1ps
module ptrd_cycle_timer
  import ptrd_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // control
  input wire logic load_i,
  input wire logic [PTRD_CNT_W-1:0] count_i,
  // status
  output logic expired_o
);
  logic [PTRD_CNT_W-1:0] remain;
  logic running;
  wire logic last_tick = running && (remain == {{(PTRD_CNT_W-1){1'b0}}, 1'b1});

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      remain <= '0;
      running <= 1'b0;
      expired_o <= 1'b0;
    end
    else
    begin
      expired_o <= last_tick && !load_i;
      if (load_i)
      begin
        remain <= count_i;
        running <= 1'b1;
      end
      else if (running)
      begin
        remain <= remain - 1'b1;
        running <= !last_tick;
      end
    end
  end
endmodule : ptrd_cycle_timer

// [dv/ptrd_far_end.sv]
// far-end line model
`timescale 1ns/1ps
module ptrd_far_end
(
  input wire logic clk_sys_i,
  input wire logic cm_step_i,
  input wire logic present_i,
  output logic cm_cross_o
);
  logic [1:0] age;
  // with no receiver the step edge is fast and crosses early
  always_ff @(posedge clk_sys_i)
  begin
    age <= cm_step_i ? {age[0], 1'h1} : 2'h0;
    cm_cross_o <= cm_step_i && !present_i && age[1];
  end
endmodule : ptrd_far_end

// [dv/ptrd_monitor.sv]
// checker for idle and receiver detect
`timescale 1ns/1ps
module ptrd_monitor
  import ptrd_pkg::*;
(
  // block ports
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic force_idle_i,
  input wire logic detect_rx_i,
  input wire logic [1:0] power_state_i,
  input wire logic cm_cross_i,
  input wire logic tx_drive_en_o,
  input wire logic cm_step_o,
  input wire logic done_o,
  input wire logic [2:0] status_o
);
  // remembers a fast crossing seen during the step
  logic seen;
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
    if (!arst_n_i)
      seen <= 1'h0;
    else
      seen <= cm_step_o && (seen || cm_cross_i);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  AST_IDLE: assert property (force_idle_i |=> !tx_drive_en_o) else $error("idle");
  AST_P1: assert property (power_state_i == PTRD_PWR_P1 |=> !tx_drive_en_o) else $error("p1");
  AST_STEP_P1: assert property ($rose(cm_step_o) |-> $past(power_state_i) == PTRD_PWR_P1) else $error("ps");
  AST_STEP_REQ: assert property ($rose(cm_step_o) |-> $past(detect_rx_i) && $past(force_idle_i)) else $error("rq");
  AST_DONE_BY: assert property ($rose(cm_step_o) |-> !done_o ##[1:30] (done_o || !cm_step_o)) else $error("late");
  AST_PULSE: assert property (done_o |=> !done_o) else $error("pulse");
  AST_CODE: assert property (done_o |-> status_o == (seen ? PTRD_STAT_NONE : PTRD_STAT_FOUND)) else $error("code");
  AST_HOLD: assert property ($changed(status_o) |-> done_o) else $error("hold");
  AST_CVR_FOUND: cover property (done_o && status_o == PTRD_STAT_FOUND);
  AST_CVR_NONE: cover property (done_o && status_o == PTRD_STAT_NONE);
  AST_CVR_START: cover property ($rose(cm_step_o));
  AST_CVR_ABORT: cover property ($fell(cm_step_o) && !done_o);
endmodule : ptrd_monitor
bind ptrd_top ptrd_monitor mon (.*);

// [dv/ptrd_top_bench.sv]
// bench for idle and receiver detect
`timescale 1ns/1ps
module ptrd_top_bench
  import ptrd_pkg::*;
;
  logic clk_sys_i = 1'h0, arst_n_i = 1'h0, force_idle_i = 1'h0, detect_rx_i = 1'h0, present = 1'h0, got;
  logic stepped, run;
  logic [1:0] power_state_i = PTRD_PWR_P0;
  logic cm_cross_i, tx_drive_en_o, cm_step_o, done_o;
  logic [2:0] status_o;
  int mismatches = 0, cmp_count = 0, cycles = 0;
  ptrd_top dut (.*);
  ptrd_far_end far (.clk_sys_i, .cm_step_i(cm_step_o), .present_i(present), .cm_cross_o(cm_cross_i));
  initial forever #20 clk_sys_i = ~clk_sys_i;
  function automatic logic [2:0] want(logic p);
    return p ? PTRD_STAT_FOUND : PTRD_STAT_NONE;
  endfunction : want
  task automatic chk(logic [2:0] g, e);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic chk_bit(logic g, e);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %0t flag got %b want %b", $time, g, e);
    end
  endtask : chk_bit
  task automatic print_verdict();
    if (mismatches == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict
  task automatic tick(int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : tick
  always @(posedge clk_sys_i)
    if (++cycles == 3000)
    begin
      mismatches++;
      print_verdict();
    end
  initial
  begin
    void'($urandom(32'h41c73075));
    tick(4);
    arst_n_i = 1'h1;
    // first four passes walk every power state
    for (int i = 0; i < 16; i++)
    begin
      power_state_i = i < 4 ? 2'(i) : i[0] ? PTRD_PWR_P1 : 2'($urandom);
      present = 1'($urandom);
      force_idle_i = 1'h1;
      tick(10 + $urandom % 3);
      detect_rx_i = 1'h1;
      got = 1'h0;
      stepped = 1'h0;
      run = power_state_i == PTRD_PWR_P1;
      for (int c = 0; c < 40 && got !== 1'h1; c++)
      begin
        tick(1);
        got = done_o;
        stepped = stepped || cm_step_o;
        chk_bit(tx_drive_en_o, 1'h0);
        // corner case: leaving p1 mid-detection must end with no result
        if (i == 7 && c == 3)
          power_state_i = PTRD_PWR_P0;
      end
      chk_bit(got, power_state_i == PTRD_PWR_P1);
      chk_bit(stepped, run);
      chk_bit(cm_step_o, 1'h0);
      if (got === 1'h1)
        chk(status_o, want(present));
      detect_rx_i = 1'h0;
      force_idle_i = 1'h0;
      tick(3);
      chk_bit(tx_drive_en_o, power_state_i != PTRD_PWR_P1);
    end
    print_verdict();
  end
endmodule : ptrd_top_bench
